// [tcmux_pkg.sv]
// Package: shared types and constants of the Type-C mux control logic
package tcmux_pkg;

  // Tri-level strap reading, as presented by the analog front end
  typedef enum logic [1:0] {
    TCMUX_STRAP_LOW   = 2'b00,
    TCMUX_STRAP_HIGH  = 2'b01,
    TCMUX_STRAP_FLOAT = 2'b10
  } tcmux_strap_t;

  // Port role
  typedef enum logic [1:0] {
    TCMUX_ROLE_SINK   = 2'b00,
    TCMUX_ROLE_SOURCE = 2'b01,
    TCMUX_ROLE_DRP    = 2'b10
  } tcmux_role_t;

  // Current level advertised or detected
  typedef enum logic [1:0] {
    TCMUX_CUR_DEFAULT = 2'b00,
    TCMUX_CUR_1A5     = 2'b01,
    TCMUX_CUR_3A      = 2'b10
  } tcmux_cur_t;

  // Control state machine
  typedef enum logic [1:0] {
    TCMUX_ST_DISABLED = 2'b00,
    TCMUX_ST_SAMPLE   = 2'b01,
    TCMUX_ST_ACTIVE   = 2'b10
  } tcmux_state_t;

  // CC sensing result from the analog comparators
  typedef struct packed {
    logic       cc1_seen;
    logic       cc2_seen;
    logic       partner_sink;
    logic       audio_adapter;
    tcmux_cur_t src_current;
  } tcmux_cc_t;

  localparam int        TCMUX_CC_W         = 6;
  localparam int        TCMUX_ADDR_BIT     = 6;
  localparam logic [6:0] TCMUX_ADDR_BASE   = 7'h1D;
  // Debounce time in ns and derived cycles at 100 MHz
  localparam int        TCMUX_CLK_NS       = 10;
  localparam int        TCMUX_DEB_NS       = 40;
  localparam int        TCMUX_DEB_CYC      = (TCMUX_DEB_NS + TCMUX_CLK_NS - 1) / TCMUX_CLK_NS;
  localparam logic [3:0] TCMUX_DEB_MAX     = 4'(TCMUX_DEB_CYC);

endpackage : tcmux_pkg

// [tcmux_debounce.sv]
// Synchroniser and debounce filter for the CC sensing word
module tcmux_debounce (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_reset,
  input  wire tcmux_pkg::tcmux_cc_t        i_raw,
  output logic                             o_changed,
  output tcmux_pkg::tcmux_cc_t             o_stable
);

  tcmux_pkg::tcmux_cc_t sync1;
  tcmux_pkg::tcmux_cc_t sync2;
  tcmux_pkg::tcmux_cc_t cand;
  tcmux_pkg::tcmux_cc_t next_cand;
  tcmux_pkg::tcmux_cc_t stable;
  tcmux_pkg::tcmux_cc_t next_stable;
  logic [3:0]           cnt;
  logic [3:0]           next_cnt;
  logic                 changed;
  logic                 next_changed;

  // ==========================================================
  // Filter
  // Candidate must hold for the full count before it is taken
  always_comb
  begin
    next_cand    = sync2;
    next_cnt     = 4'h0;
    next_stable  = stable;
    next_changed = 1'b0;
    if (sync2 == cand)
    begin
      if (cnt < tcmux_pkg::TCMUX_DEB_MAX)
        next_cnt = cnt + 4'h1;
      else
        next_cnt = cnt;
      if (cnt == tcmux_pkg::TCMUX_DEB_MAX - 4'h1 && stable != cand)
      begin
        next_stable  = cand;
        next_changed = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      sync1   <= '0;
      sync2   <= '0;
      cand    <= '0;
      cnt     <= 4'h0;
      stable  <= '0;
      changed <= 1'b0;
    end
    else
    begin
      sync1   <= i_raw;
      sync2   <= sync1;
      cand    <= next_cand;
      cnt     <= next_cnt;
      stable  <= next_stable;
      changed <= next_changed;
    end
  end

  assign o_stable  = stable;
  assign o_changed = changed;

  // ==========================================================
  // Checks
  a_glitch_blocked: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (sync2 != $past(sync2)) |=> (stable == $past(stable)))
    else $error("Stable word moved right after an input change");

endmodule : tcmux_debounce

// [tcmux_ctrl.sv]
// Control logic of a Type-C high-speed mux: straps, CC steering, indicators
module tcmux_ctrl (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_reset,
  input  wire logic                     i_chip_enable_n,
  input  wire tcmux_pkg::tcmux_strap_t  i_mode_strap,
  input  wire tcmux_pkg::tcmux_strap_t  i_role_strap,
  input  wire tcmux_pkg::tcmux_cc_t     i_cc_sense,
  input  wire logic                     i_bus_power_sense,
  input  wire tcmux_pkg::tcmux_cur_t    i_sw_current,
  input  wire logic                     i_attention_clear,
  input  wire logic                     i_dual_as_source,
  output logic                          o_i2c_mode,
  output logic [6:0]                    o_target_addr,
  output tcmux_pkg::tcmux_role_t        o_role,
  output tcmux_pkg::tcmux_cur_t         o_adv_current,
  output logic                          o_mux_pos2,
  output logic                          o_mux_on,
  output logic                          o_low_power,
  output logic                          o_current_level_ind_lo_oe,
  output logic                          o_current_level_ind_hi_oe,
  output logic                          o_audio_adapter_flag_oe,
  output logic                          o_attention_n_oe,
  output logic                          o_attach_indicator_n_oe
);

  tcmux_pkg::tcmux_state_t state;
  tcmux_pkg::tcmux_state_t next_state;
  tcmux_pkg::tcmux_cc_t    cc;
  logic                    cc_changed;
  logic                    i2c_mode;
  logic                    next_i2c_mode;
  logic [6:0]              addr;
  logic [6:0]              next_addr;
  tcmux_pkg::tcmux_role_t  role;
  tcmux_pkg::tcmux_role_t  next_role;
  logic                    bus_power;
  logic                    bus_power_prev;
  logic                    attn;
  logic                    next_attn;
  logic                    as_source;
  logic                    active;

  tcmux_debounce u_deb (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_raw      (i_cc_sense),
    .o_changed  (cc_changed),
    .o_stable   (cc)
  );

  // ==========================================================
  // Enable and strap capture
  always_comb
  begin
    next_state    = state;
    next_i2c_mode = i2c_mode;
    next_addr     = addr;
    next_role     = role;
    case (state)
      tcmux_pkg::TCMUX_ST_DISABLED:
        if (!i_chip_enable_n)
          next_state = tcmux_pkg::TCMUX_ST_SAMPLE;
      tcmux_pkg::TCMUX_ST_SAMPLE:
      begin
        // Straps read once, so a drifting strap cannot flip mode mid-session
        next_i2c_mode = (i_mode_strap != tcmux_pkg::TCMUX_STRAP_FLOAT);
        next_addr     = tcmux_pkg::TCMUX_ADDR_BASE;
        next_addr[tcmux_pkg::TCMUX_ADDR_BIT] = (i_mode_strap == tcmux_pkg::TCMUX_STRAP_HIGH);
        case (i_role_strap)
          tcmux_pkg::TCMUX_STRAP_HIGH: next_role = tcmux_pkg::TCMUX_ROLE_SOURCE;
          tcmux_pkg::TCMUX_STRAP_LOW:  next_role = tcmux_pkg::TCMUX_ROLE_SINK;
          default:                     next_role = tcmux_pkg::TCMUX_ROLE_DRP;
        endcase
        next_state = i_chip_enable_n ? tcmux_pkg::TCMUX_ST_DISABLED
                                     : tcmux_pkg::TCMUX_ST_ACTIVE;
      end
      tcmux_pkg::TCMUX_ST_ACTIVE:
        if (i_chip_enable_n)
          next_state = tcmux_pkg::TCMUX_ST_DISABLED;
      default:
        next_state = tcmux_pkg::TCMUX_ST_DISABLED;
    endcase
  end

  assign active    = (state == tcmux_pkg::TCMUX_ST_ACTIVE);
  assign as_source = (role == tcmux_pkg::TCMUX_ROLE_SOURCE) ||
                     (role == tcmux_pkg::TCMUX_ROLE_DRP && i_dual_as_source);

  // ==========================================================
  // Attention: change sets, host clear loses to a same-cycle change
  always_comb
  begin
    next_attn = attn;
    if (i_attention_clear)
      next_attn = 1'b0;
    if (active && i2c_mode && (cc_changed || bus_power != bus_power_prev))
      next_attn = 1'b1;
    if (!active)
      next_attn = 1'b0;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state          <= tcmux_pkg::TCMUX_ST_DISABLED;
      i2c_mode       <= 1'b0;
      addr           <= 7'h00;
      role           <= tcmux_pkg::TCMUX_ROLE_SINK;
      attn           <= 1'b0;
      bus_power      <= 1'b0;
      bus_power_prev <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      i2c_mode       <= next_i2c_mode;
      addr           <= next_addr;
      role           <= next_role;
      attn           <= next_attn;
      bus_power      <= i_bus_power_sense;
      bus_power_prev <= bus_power;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_i2c_mode                <= 1'b0;
      o_target_addr             <= 7'h00;
      o_role                    <= tcmux_pkg::TCMUX_ROLE_SINK;
      o_adv_current             <= tcmux_pkg::TCMUX_CUR_DEFAULT;
      o_mux_pos2                <= 1'b0;
      o_mux_on                  <= 1'b0;
      o_low_power               <= 1'b1;
      o_current_level_ind_lo_oe <= 1'b0;
      o_current_level_ind_hi_oe <= 1'b0;
      o_audio_adapter_flag_oe   <= 1'b0;
      o_attention_n_oe          <= 1'b0;
      o_attach_indicator_n_oe   <= 1'b0;
    end
    else
    begin
      o_i2c_mode    <= i2c_mode;
      o_target_addr <= addr;
      o_role        <= role;
      o_low_power   <= !active;
      o_adv_current <= i2c_mode ? i_sw_current
                                : tcmux_pkg::TCMUX_CUR_DEFAULT;
      // Position 2 only when CC2 alone sees the partner
      o_mux_on   <= active && (cc.cc1_seen || cc.cc2_seen);
      o_mux_pos2 <= active && cc.cc2_seen && !cc.cc1_seen;
      o_current_level_ind_lo_oe <= active && !i2c_mode && !as_source &&
                                   cc.src_current != tcmux_pkg::TCMUX_CUR_DEFAULT;
      o_current_level_ind_hi_oe <= active && !i2c_mode && !as_source &&
                                   cc.src_current == tcmux_pkg::TCMUX_CUR_3A;
      o_audio_adapter_flag_oe <= active && !i2c_mode && cc.audio_adapter;
      o_attention_n_oe        <= active && i2c_mode && attn;
      o_attach_indicator_n_oe <= active && as_source && cc.partner_sink;
    end
  end

  // ==========================================================
  // Checks
  a_disable_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_chip_enable_n [*3] |=> !o_attach_indicator_n_oe && o_low_power)
    else $error("Outputs active while disabled");
  a_strap_held: assert property (@(posedge i_core_clk) disable iff (i_reset)
    active && $past(active) |-> $stable(i2c_mode) && $stable(role))
    else $error("Strap result changed while active");
  a_mode_decode: assert property (@(posedge i_core_clk) disable iff (i_reset)
    state == tcmux_pkg::TCMUX_ST_SAMPLE && !i_chip_enable_n |=>
      i2c_mode == ($past(i_mode_strap) != tcmux_pkg::TCMUX_STRAP_FLOAT))
    else $error("Mode strap decoded wrongly");
  a_addr_bit: assert property (@(posedge i_core_clk) disable iff (i_reset)
    state == tcmux_pkg::TCMUX_ST_SAMPLE |=>
      addr[6] == ($past(i_mode_strap) == tcmux_pkg::TCMUX_STRAP_HIGH))
    else $error("Address bit 6 wrong");
  a_role_source: assert property (@(posedge i_core_clk) disable iff (i_reset)
    state == tcmux_pkg::TCMUX_ST_SAMPLE && i_role_strap == tcmux_pkg::TCMUX_STRAP_HIGH
      |=> role == tcmux_pkg::TCMUX_ROLE_SOURCE)
    else $error("Role strap high not source");
  a_level_code: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_current_level_ind_hi_oe |-> o_current_level_ind_lo_oe && !o_i2c_mode)
    else $error("Current level code illegal");
  a_attn_pin: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_attention_n_oe |-> o_i2c_mode && !o_audio_adapter_flag_oe)
    else $error("Attention driven outside I2C mode");
  a_pin_default: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !i2c_mode |=> o_adv_current == tcmux_pkg::TCMUX_CUR_DEFAULT)
    else $error("Pin mode advertised non-default current");
  a_sw_current: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i2c_mode |=> o_adv_current == $past(i_sw_current))
    else $error("Software current not applied");
  a_attach_src: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_attach_indicator_n_oe |-> $past(as_source) && $past(cc.partner_sink))
    else $error("Attach indicator without source attach");
  a_orient: assert property (@(posedge i_core_clk) disable iff (i_reset)
    active && cc.cc1_seen |=> !o_mux_pos2)
    else $error("Mux position wrong for CC1");

  c_i2c_attn:  cover property (@(posedge i_core_clk) o_attention_n_oe);
  c_attach:    cover property (@(posedge i_core_clk) o_attach_indicator_n_oe);
  c_pos2:      cover property (@(posedge i_core_clk) o_mux_pos2);
  c_level_hi:  cover property (@(posedge i_core_clk) o_current_level_ind_hi_oe);

endmodule : tcmux_ctrl

// [tcmux_port_partner.sv]
// Port partner model: drives the CC sensing word seen by the mux control
module tcmux_port_partner (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_attached,
  input  wire logic                  i_flipped,
  input  wire logic                  i_is_sink,
  input  wire logic                  i_audio,
  input  wire tcmux_pkg::tcmux_cur_t i_cur,
  input  wire logic                  i_glitch,
  output tcmux_pkg::tcmux_cc_t       o_cc
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Plug model
  // Only one CC line sees a plug; glitch is a short false hit on CC1
  always_ff @(posedge i_core_clk)
  begin
    o_cc.cc1_seen      <= (i_attached & ~i_flipped) | i_glitch;
    o_cc.cc2_seen      <= i_attached & i_flipped;
    o_cc.partner_sink  <= i_attached & i_is_sink;
    o_cc.audio_adapter <= i_attached & i_audio;
    o_cc.src_current   <= i_attached ? i_cur : tcmux_pkg::TCMUX_CUR_DEFAULT;
  end
endmodule : tcmux_port_partner

// [tb_top.sv]
// Self-checking testbench of the Type-C mux control logic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic i_core_clk, i_reset, i_chip_enable_n, i_bus_power_sense;
  logic i_attention_clear, i_dual_as_source;
  tcmux_pkg::tcmux_strap_t i_mode_strap, i_role_strap;
  tcmux_pkg::tcmux_cc_t    i_cc_sense;
  tcmux_pkg::tcmux_cur_t   i_sw_current, p_cur;
  logic p_att, p_flip, p_sink, p_audio, p_glitch;
  logic o_i2c_mode, o_mux_pos2, o_mux_on, o_low_power;
  logic [6:0] o_target_addr;
  tcmux_pkg::tcmux_role_t o_role;
  tcmux_pkg::tcmux_cur_t  o_adv_current;
  logic o_lo_oe, o_hi_oe, o_audio_oe, o_attn_oe, o_attach_oe;
  int errors, total_checks, seed, k;
  tcmux_pkg::tcmux_strap_t straps [3];
  tcmux_pkg::tcmux_cur_t   cur;
  // ==========================================================
  // Instances
  tcmux_ctrl DUT (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_chip_enable_n(i_chip_enable_n), .i_mode_strap(i_mode_strap),
    .i_role_strap(i_role_strap), .i_cc_sense(i_cc_sense),
    .i_bus_power_sense(i_bus_power_sense), .i_sw_current(i_sw_current),
    .i_attention_clear(i_attention_clear), .i_dual_as_source(i_dual_as_source),
    .o_i2c_mode(o_i2c_mode), .o_target_addr(o_target_addr), .o_role(o_role),
    .o_adv_current(o_adv_current), .o_mux_pos2(o_mux_pos2), .o_mux_on(o_mux_on),
    .o_low_power(o_low_power), .o_current_level_ind_lo_oe(o_lo_oe),
    .o_current_level_ind_hi_oe(o_hi_oe), .o_audio_adapter_flag_oe(o_audio_oe),
    .o_attention_n_oe(o_attn_oe), .o_attach_indicator_n_oe(o_attach_oe));
  tcmux_port_partner partner (.i_core_clk(i_core_clk), .i_attached(p_att),
    .i_flipped(p_flip), .i_is_sink(p_sink), .i_audio(p_audio), .i_cur(p_cur),
    .i_glitch(p_glitch), .o_cc(i_cc_sense));
  // ==========================================================
  // Clock and watchdog
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    #100000;
    errors++;
    end_of_test();
  end
  // ==========================================================
  // Helpers
  task automatic cycles(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : cycles
  task automatic check(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Straps only count when taken on leaving the disabled state
  task automatic power_up(input tcmux_pkg::tcmux_strap_t m, input tcmux_pkg::tcmux_strap_t r);
    i_chip_enable_n = 1'b1;
    cycles(3);
    i_mode_strap    = m;
    i_role_strap    = r;
    i_chip_enable_n = 1'b0;
    cycles(5);
  endtask : power_up
  // Debounce path is about nine cycles; twelve leaves margin
  task automatic plug(input logic a, f, s, au, input tcmux_pkg::tcmux_cur_t c);
    p_att   = a;
    p_flip  = f;
    p_sink  = s;
    p_audio = au;
    p_cur   = c;
    cycles(12);
  endtask : plug
  // Clear pulse stands for a status read walked up from register zero
  task automatic clear_attn();
    i_attention_clear = 1'b1;
    cycles(1);
    i_attention_clear = 1'b0;
    cycles(2);
  endtask : clear_attn
  function automatic logic [6:0] exp_role(input tcmux_pkg::tcmux_strap_t s);
    if (s == tcmux_pkg::TCMUX_STRAP_HIGH) return 7'(tcmux_pkg::TCMUX_ROLE_SOURCE);
    if (s == tcmux_pkg::TCMUX_STRAP_LOW) return 7'(tcmux_pkg::TCMUX_ROLE_SINK);
    return 7'(tcmux_pkg::TCMUX_ROLE_DRP);
  endfunction : exp_role
  function automatic logic [6:0] exp_addr(input tcmux_pkg::tcmux_strap_t s);
    return {s == tcmux_pkg::TCMUX_STRAP_HIGH, tcmux_pkg::TCMUX_ADDR_BASE[5:0]};
  endfunction : exp_addr
  function automatic logic [6:0] exp_ind(input tcmux_pkg::tcmux_cur_t c);
    if (c == tcmux_pkg::TCMUX_CUR_3A) return 7'h03;
    if (c == tcmux_pkg::TCMUX_CUR_1A5) return 7'h01;
    return 7'h00;
  endfunction : exp_ind
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 80479;
    errors = 0;
    total_checks = 0;
    {i_bus_power_sense, i_attention_clear, i_dual_as_source} = 3'b000;
    {p_att, p_flip, p_sink, p_audio, p_glitch} = 5'b00000;
    p_cur = tcmux_pkg::TCMUX_CUR_DEFAULT;
    i_sw_current = tcmux_pkg::TCMUX_CUR_DEFAULT;
    i_chip_enable_n = 1'b1;
    i_mode_strap = tcmux_pkg::TCMUX_STRAP_FLOAT;
    i_role_strap = tcmux_pkg::TCMUX_STRAP_FLOAT;
    straps = '{tcmux_pkg::TCMUX_STRAP_LOW, tcmux_pkg::TCMUX_STRAP_HIGH,
               tcmux_pkg::TCMUX_STRAP_FLOAT};
    i_reset = 1'b1;
    cycles(4);
    i_reset = 1'b0;
    foreach (straps[i])
    begin
      power_up(tcmux_pkg::TCMUX_STRAP_FLOAT, straps[i]);
      check(o_i2c_mode, 7'h00);
      check(o_role, exp_role(straps[i]));
      check(o_low_power, 7'h00);
      if (i < 2)
      begin
        power_up(straps[i], tcmux_pkg::TCMUX_STRAP_FLOAT);
        check(o_i2c_mode, 7'h01);
        check(o_target_addr, exp_addr(straps[i]));
      end
    end
    $display("test straps done");
    power_up(tcmux_pkg::TCMUX_STRAP_FLOAT, tcmux_pkg::TCMUX_STRAP_LOW);
    for (k = 0; k < 8; k++)
    begin
      cur = tcmux_pkg::tcmux_cur_t'(k < 3 ? k : $unsigned($random(seed)) % 3);
      plug(1'b1, k[0], 1'b0, 1'b0, cur);
      check({o_hi_oe, o_lo_oe}, exp_ind(cur));
      check({o_mux_on, o_mux_pos2}, {1'b1, k[0]});
    end
    plug(1'b1, 1'b0, 1'b0, 1'b1, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_audio_oe, 7'h01);
    plug(1'b0, 1'b0, 1'b0, 1'b0, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_audio_oe, 7'h00);
    $display("test sink done");
    power_up(tcmux_pkg::TCMUX_STRAP_FLOAT, tcmux_pkg::TCMUX_STRAP_HIGH);
    plug(1'b1, 1'b0, 1'b1, 1'b0, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_attach_oe, 7'h01);
    check(o_adv_current, 7'(tcmux_pkg::TCMUX_CUR_DEFAULT));
    i_role_strap = tcmux_pkg::TCMUX_STRAP_LOW;
    cycles(3);
    check(o_role, 7'(tcmux_pkg::TCMUX_ROLE_SOURCE));
    plug(1'b0, 1'b0, 1'b0, 1'b0, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_attach_oe, 7'h00);
    // Two-cycle spike must not move the mux
    p_glitch = 1'b1;
    cycles(2);
    p_glitch = 1'b0;
    // Watched every cycle, as a passed spike would be gone again by the end
    for (k = 0; k < 10; k++)
    begin
      cycles(1);
      check(o_mux_on, 7'h00);
    end
    power_up(tcmux_pkg::TCMUX_STRAP_FLOAT, tcmux_pkg::TCMUX_STRAP_FLOAT);
    i_dual_as_source = 1'b1;
    plug(1'b1, 1'b1, 1'b1, 1'b0, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_attach_oe, 7'h01);
    $display("test source done");
    power_up(tcmux_pkg::TCMUX_STRAP_HIGH, tcmux_pkg::TCMUX_STRAP_FLOAT);
    check(o_attach_oe, 7'h01);
    for (k = 0; k < 3; k++)
    begin
      i_sw_current = tcmux_pkg::tcmux_cur_t'(k);
      cycles(4);
      check(o_adv_current, 7'(k));
    end
    clear_attn();
    check(o_attn_oe, 7'h00);
    plug(1'b0, 1'b0, 1'b0, 1'b0, tcmux_pkg::TCMUX_CUR_DEFAULT);
    check(o_attn_oe, 7'h01);
    check(o_attach_oe, 7'h00);
    clear_attn();
    check(o_attn_oe, 7'h00);
    i_bus_power_sense = 1'b1;
    cycles(12);
    check(o_attn_oe, 7'h01);
    clear_attn();
    check(o_attn_oe, 7'h00);
    i_chip_enable_n = 1'b1;
    cycles(3);
    check(o_low_power, 7'h01);
    check({o_attach_oe, o_attn_oe}, 7'h00);
    $display("test i2c and disable done");
    end_of_test();
  end
endmodule : tb_top
